// ==== rtl/vwfc_fifo.v ====
`timescale 1ns/1ps
// Synchronous FIFO with valid/ready on both sides.
module vwfc_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire reset_n,
    input wire flush,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    reg [AW:0] countNext;
    reg full_q;
    wire push;
    wire pop;

    // Ready comes from a registered full flag so the upstream port sees a flop.
    assign inReady = !full_q;
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Occupancy after this cycle's push and pop.
    always @*
    begin
        countNext = count_q;
        if (push && !pop)
        begin
            countNext = count_q + {{AW{1'b0}}, 1'b1};
        end
        else if (pop && !push)
        begin
            countNext = count_q - {{AW{1'b0}}, 1'b1};
        end
    end

    // Storage array write.
    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and count.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            full_q <= 1'b0;
        end
        else if (flush)
        begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            full_q <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            count_q <= countNext;
            full_q <= (countNext == DEPTH[AW:0]);
        end
    end
endmodule

// ==== rtl/vwfc_regs.vh ====
`ifndef VWFC_REGS_VH
`define VWFC_REGS_VH
// Register indices on the indexed port.
`define VWFC_IDX_START_HIGH 8'h3a
`define VWFC_IDX_PAN_OFFSET 8'h3b
`define VWFC_IDX_DATA_FORMAT 8'h3c
`define VWFC_IDX_PIXEL_WIDTH 8'h3d
`define VWFC_IDX_START_MIDDLE 8'h3e
`define VWFC_IDX_INTERP_LOW 8'h3f
`define VWFC_IDX_SHARPEN 8'h40
`define VWFC_IDX_VERT_EXT 8'h36
`define VWFC_IDX_KEY_SELECT 8'h42
`define VWFC_RESET_BYTE 8'h00
`define VWFC_RESET_VERT_EXT 8'h20
// Field positions.
`define VWFC_BIT_INVERT_CLK 7
`define VWFC_BIT_ENABLE 4
`define VWFC_BIT_WIDTH0 5
`define VWFC_BIT_HINTERP 7
`define VWFC_BIT_VINTERP 6
`define VWFC_BIT_OCCLUDE 5
`define VWFC_BIT_PALETTE 4
`define VWFC_BIT_PAN_MSB 4
`define VWFC_BIT_PENDING 4
`define VWFC_BIT_KEYSEL 0
// Encoding codes.
`define VWFC_FMT_OFF 4'h0
`define VWFC_FMT_RGB555 4'h1
`define VWFC_FMT_COMPRESSED 4'h2
`define VWFC_FMT_YUV422 4'h3
`define VWFC_FMT_RGB565 4'h4
`define VWFC_FMT_DELTA_YUV 4'h5
// Fetch FIFO geometry.
`define VWFC_FIFO_WIDTH 64
`define VWFC_FIFO_DEPTH 8
`define VWFC_FIFO_AW 3
`endif

// ==== rtl/vwfc_top.v ====
// Summary of operation
// (R1) Bit 7 high inverts the accelerator clock.
// (R2) Start address assembled from four register fields.
// (R3) Address bit 0 picks 64 or 32-bit alignment.
// (R4) Start address counts 64-bit quadword units.
// (R5) High-only address aligns window on 16 KB.
// (R6) Software writes bit0, high, middle, low order.
// (R7) Writing the low register commits the address.
// (R8) Nine-bit pan offset from two registers.
// (R9) Next start adds twice the offset.
// (R10) Source image up to 2K pixels wide.
// (R11) Enable bit shows window and fetches data.
// (R12) Enable change applies at next vsync edge.
// (R13) Four-bit encoding field decoded into formats.
// (R14) YUV memory order Y0 U Y1 V.
// (R15) Software never programs codes 6 through F.
// (R16) Eleven-bit width assembled from two registers.
// (R17) Software programs width minus one, minimum 32.
// (R18) Horizontal interpolation or replication select.
// (R19) Vertical interpolation or replication select.
// (R20) Occlusion lets graphics replace video by key.
// (R21) Key select chooses color or chroma key.
// (R22) Palette select routes host lookup RAM access.
// (R23) Pending bit set by software, hardware clears.
`timescale 1ns/1ps
`include "vwfc_regs.vh"
module vwfc_top (
    input wire clk,
    input wire reset_n,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regIndex,
    input wire [7:0] regWriteData,
    output reg [7:0] regReadData,
    input wire vsyncPin,
    input wire frameDonePin,
    input wire hCoeffNonZero,
    input wire vCoeffNonZero,
    input wire [63:0] memData,
    input wire memDataValid,
    output wire memDataReady,
    input wire fetchNext,
    output reg [19:0] fetchAddress,
    output reg fetchHalfAlign,
    output reg windowVisible,
    output reg [3:0] dataFormat,
    output reg formatYuvSwap,
    output reg [10:0] pixelWidth,
    output reg hInterpolate,
    output reg hReplicate,
    output reg vInterpolate,
    output reg vReplicate,
    output reg occludeColorKey,
    output reg occludeChromaKey,
    output reg paletteVideoSelect,
    output reg invertAccelClock,
    output reg align16k,
    output reg pixelValid,
    output reg [63:0] pixelData,
    input wire pixelReady
);
    reg [7:0] startHigh_q;
    reg [7:0] panOffset_q;
    reg [7:0] dataFormat_q;
    reg [7:0] pixelWidth_q;
    reg [7:0] startMiddle_q;
    reg [7:0] interpLow_q;
    reg [7:0] sharpen_q;
    reg [7:0] vertExt_q;
    reg [7:0] keySelect_q;
    reg [19:0] committedStart_q;
    reg [19:0] fetchAddress_d;
    reg enableActive_q;
    reg vsyncMeta_q;
    reg vsyncSync_q;
    reg vsyncPrev_q;
    reg doneMeta_q;
    reg doneSync_q;
    reg donePrev_q;
    reg commitSeen_q;
    reg [7:0] readMux;
    wire vsyncRise;
    wire doneRise;
    wire [19:0] assembledStart;
    wire [8:0] panOffset;
    wire [19:0] panStep;
    wire lowWrite;
    wire fifoOutValid;
    wire fifoOutReady;
    wire [63:0] fifoOutData;

    // Address, offset and pan step field assembly.
    assign assembledStart = {startHigh_q[6:0], startMiddle_q, interpLow_q[3:0], sharpen_q[0]}; // R2 R4
    assign panOffset = {vertExt_q[`VWFC_BIT_PAN_MSB], panOffset_q}; // R8
    assign panStep = {10'h000, panOffset, 1'b0}; // R9 R10
    assign lowWrite = regWrite && (regIndex == `VWFC_IDX_INTERP_LOW); // R7

    // Edge detectors read only the second and third synchroniser stages.
    assign vsyncRise = vsyncSync_q && !vsyncPrev_q;
    assign doneRise = doneSync_q && !donePrev_q;

    // Pin synchronisers for vertical sync and frame completion.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vsyncMeta_q <= 1'b0;
            vsyncSync_q <= 1'b0;
            vsyncPrev_q <= 1'b0;
            doneMeta_q <= 1'b0;
            doneSync_q <= 1'b0;
            donePrev_q <= 1'b0;
        end
        else
        begin
            vsyncMeta_q <= vsyncPin;
            vsyncSync_q <= vsyncMeta_q;
            vsyncPrev_q <= vsyncSync_q;
            doneMeta_q <= frameDonePin;
            doneSync_q <= doneMeta_q;
            donePrev_q <= doneSync_q;
        end
    end

    // Register file writes through the indexed port.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            startHigh_q <= `VWFC_RESET_BYTE;
            panOffset_q <= `VWFC_RESET_BYTE;
            dataFormat_q <= `VWFC_RESET_BYTE;
            pixelWidth_q <= `VWFC_RESET_BYTE;
            startMiddle_q <= `VWFC_RESET_BYTE;
            interpLow_q <= `VWFC_RESET_BYTE;
            sharpen_q <= `VWFC_RESET_BYTE;
            vertExt_q <= `VWFC_RESET_VERT_EXT;
            keySelect_q <= `VWFC_RESET_BYTE;
        end
        else
        begin
            if (regWrite)
            begin
                case (regIndex)
                    `VWFC_IDX_START_HIGH: startHigh_q <= regWriteData;
                    `VWFC_IDX_PAN_OFFSET: panOffset_q <= regWriteData;
                    `VWFC_IDX_DATA_FORMAT: dataFormat_q <= regWriteData;
                    `VWFC_IDX_PIXEL_WIDTH: pixelWidth_q <= regWriteData;
                    `VWFC_IDX_START_MIDDLE: startMiddle_q <= regWriteData;
                    `VWFC_IDX_INTERP_LOW: interpLow_q <= regWriteData;
                    `VWFC_IDX_SHARPEN: sharpen_q <= regWriteData;
                    `VWFC_IDX_VERT_EXT: vertExt_q <= regWriteData;
                    `VWFC_IDX_KEY_SELECT: keySelect_q <= regWriteData;
                    default: keySelect_q <= keySelect_q;
                endcase
            end
            // Hardware clears pending after a refresh; a software set in the same cycle wins.
            if (doneRise && commitSeen_q &&
                !(regWrite && (regIndex == `VWFC_IDX_KEY_SELECT) && regWriteData[`VWFC_BIT_PENDING]))
            begin
                keySelect_q[`VWFC_BIT_PENDING] <= 1'b0; // R23
            end
        end
    end

    // Live fetch address: commit load, panning step and reload at vsync.
    always @*
    begin
        fetchAddress_d = fetchAddress;
        if (lowWrite)
        begin
            fetchAddress_d = {startHigh_q[6:0], startMiddle_q, regWriteData[3:0], sharpen_q[0]}; // R6 R7
        end
        else if (fetchNext)
        begin
            fetchAddress_d = fetchAddress + panStep; // R9
        end
        else if (vsyncRise)
        begin
            fetchAddress_d = committedStart_q;
        end
    end

    // Committed start and the flag set at the first vsync after a commit.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            committedStart_q <= 20'h00000;
            commitSeen_q <= 1'b0;
        end
        else
        begin
            if (lowWrite)
            begin
                committedStart_q <= fetchAddress_d; // R7
                commitSeen_q <= 1'b0;
            end
            else if (vsyncRise)
            begin
                commitSeen_q <= 1'b1;
            end
        end
    end

    // Enable takes effect only on the vertical sync leading edge.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enableActive_q <= 1'b0;
        end
        else if (vsyncRise)
        begin
            enableActive_q <= dataFormat_q[`VWFC_BIT_ENABLE]; // R12
        end
    end

    // Fetch address and its alignment flag, registered together so they never disagree.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fetchAddress <= 20'h00000;
            fetchHalfAlign <= 1'b0;
        end
        else
        begin
            fetchAddress <= fetchAddress_d;
            fetchHalfAlign <= fetchAddress_d[0]; // R3
        end
    end

    // Visibility follows the enable as applied at vertical sync.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            windowVisible <= 1'b0;
        end
        else
        begin
            windowVisible <= enableActive_q; // R11
        end
    end

    // Encoding format, byte order flag and assembled pixel width.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dataFormat <= `VWFC_FMT_OFF;
            formatYuvSwap <= 1'b0;
            pixelWidth <= 11'h000;
        end
        else
        begin
            dataFormat <= dataFormat_q[3:0]; // R13
            formatYuvSwap <= (dataFormat_q[3:0] == `VWFC_FMT_YUV422); // R14
            pixelWidth <= {dataFormat_q[7:6], pixelWidth_q, dataFormat_q[`VWFC_BIT_WIDTH0]}; // R16
        end
    end

    // Scaling modes, occlusion keys, palette routing and test outputs.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hInterpolate <= 1'b0;
            hReplicate <= 1'b0;
            vInterpolate <= 1'b0;
            vReplicate <= 1'b0;
            occludeColorKey <= 1'b0;
            occludeChromaKey <= 1'b0;
            paletteVideoSelect <= 1'b0;
            invertAccelClock <= 1'b0;
            align16k <= 1'b0;
        end
        else
        begin
            // Interpolation wins; replication only applies with a non-zero coefficient.
            hInterpolate <= interpLow_q[`VWFC_BIT_HINTERP]; // R18
            hReplicate <= !interpLow_q[`VWFC_BIT_HINTERP] && hCoeffNonZero; // R18
            vInterpolate <= interpLow_q[`VWFC_BIT_VINTERP]; // R19
            vReplicate <= !interpLow_q[`VWFC_BIT_VINTERP] && vCoeffNonZero; // R19
            // The two keys are exclusive and only act inside an enabled window.
            occludeColorKey <= enableActive_q && interpLow_q[`VWFC_BIT_OCCLUDE] &&
                !keySelect_q[`VWFC_BIT_KEYSEL]; // R20 R21
            occludeChromaKey <= enableActive_q && interpLow_q[`VWFC_BIT_OCCLUDE] &&
                keySelect_q[`VWFC_BIT_KEYSEL]; // R20 R21
            paletteVideoSelect <= interpLow_q[`VWFC_BIT_PALETTE]; // R22
            invertAccelClock <= startHigh_q[`VWFC_BIT_INVERT_CLK]; // R1
            // Only the high field may be non-zero for the coarse alignment case.
            align16k <= (startHigh_q[6:0] != 7'h00) && (startMiddle_q == 8'h00) &&
                (interpLow_q[3:0] == 4'h0) && !sharpen_q[0]; // R5
        end
    end

    // Readback multiplexer.
    always @*
    begin
        case (regIndex)
            `VWFC_IDX_START_HIGH: readMux = startHigh_q;
            `VWFC_IDX_PAN_OFFSET: readMux = panOffset_q;
            `VWFC_IDX_DATA_FORMAT: readMux = dataFormat_q;
            `VWFC_IDX_PIXEL_WIDTH: readMux = pixelWidth_q;
            `VWFC_IDX_START_MIDDLE: readMux = startMiddle_q;
            `VWFC_IDX_INTERP_LOW: readMux = interpLow_q;
            `VWFC_IDX_SHARPEN: readMux = sharpen_q;
            `VWFC_IDX_VERT_EXT: readMux = vertExt_q;
            `VWFC_IDX_KEY_SELECT: readMux = keySelect_q;
            default: readMux = `VWFC_RESET_BYTE;
        endcase
    end

    // Read data is registered one cycle after the read strobe.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regReadData <= `VWFC_RESET_BYTE;
        end
        else if (regRead)
        begin
            regReadData <= readMux;
        end
    end

    // Fetched window data flows through the FIFO; flushed while disabled.
    vwfc_fifo #(
        .WIDTH(`VWFC_FIFO_WIDTH),
        .DEPTH(`VWFC_FIFO_DEPTH),
        .AW(`VWFC_FIFO_AW)
    ) fetchFifo (
        .clk(clk),
        .reset_n(reset_n),
        .flush(!enableActive_q), // R11
        .inValid(memDataValid),
        .inReady(memDataReady),
        .inData(memData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // Output stage register with stall toward the FIFO.
    assign fifoOutReady = !pixelValid || pixelReady;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pixelValid <= 1'b0;
            pixelData <= 64'h0000000000000000;
        end
        else if (fifoOutReady)
        begin
            pixelValid <= fifoOutValid;
            pixelData <= fifoOutData;
        end
    end
endmodule

// ==== tb/vwfc_mem_model.sv ====
`timescale 1ns/1ps
// Display memory source sending counting words, with optional idle gaps.
module vwfc_mem_model (
    input wire clk,
    input wire reset_n,
    input wire slow,
    input wire memDataReady,
    output logic memDataValid,
    output logic [63:0] memData
);
    logic [63:0] word;
    // Holds each word until taken; an idle bus shows scrambled data.
    initial
    begin
        memDataValid = 1'b0;
        memData = 64'h0;
        word = 64'h1;
        forever
        begin
            @(posedge clk);
            #1;
            if (memDataValid && memDataReady)
            begin
                word = word + 64'h1;
                memDataValid = !slow;
            end
            else if (!memDataValid)
                memDataValid = reset_n;
            memData = memDataValid ? word : ~memData;
        end
    end
endmodule

// ==== tb/vwfc_top_asserts.sv ====
`timescale 1ns/1ps
// Checks the fetch control outputs against register traffic.
module vwfc_top_asserts (
    input wire clk,
    input wire reset_n,
    input wire regWrite,
    input wire [7:0] regIndex,
    input wire [7:0] regWriteData,
    input wire vsyncPin,
    input wire fetchNext,
    input wire [19:0] fetchAddress,
    input wire fetchHalfAlign,
    input wire windowVisible,
    input wire [3:0] dataFormat,
    input wire formatYuvSwap,
    input wire hInterpolate,
    input wire hReplicate,
    input wire vInterpolate,
    input wire vReplicate,
    input wire occludeColorKey,
    input wire occludeChromaKey,
    input wire pixelValid,
    input wire [63:0] pixelData,
    input wire pixelReady
);
    reg [3:0] vsAge_q;
    reg vsPrev_q;
    wire lowWrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // A write to the low start register commits the address.
    assign lowWrite = regWrite && regIndex == 8'h3f;
    // Counts cycles since the vsync pin rose, saturating.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vsAge_q <= 4'hf;
            vsPrev_q <= 1'b0;
        end
        else
        begin
            vsPrev_q <= vsyncPin;
            if (vsyncPin && !vsPrev_q)
                vsAge_q <= 4'h0;
            else if (vsAge_q != 4'hf)
                vsAge_q <= vsAge_q + 4'h1;
        end
    end
    property p_commit;
        lowWrite |=> fetchAddress[4:1] == $past(regWriteData[3:0]);
    endproperty
    a_commit: assert property (p_commit) else $error("Low address bits not committed.");
    property p_half;
        fetchHalfAlign == fetchAddress[0];
    endproperty
    a_half: assert property (p_half) else $error("Alignment flag differs from address bit 0.");
    property p_hold;
        !lowWrite && !fetchNext && vsAge_q > 4'h8 |=> $stable(fetchAddress);
    endproperty
    a_hold: assert property (p_hold) else $error("Fetch address moved without cause.");
    property p_vis;
        $changed(windowVisible) |-> vsAge_q < 4'h8;
    endproperty
    a_vis: assert property (p_vis) else $error("Window visibility changed away from vsync.");
    property p_stall;
        pixelValid && !pixelReady |=> pixelValid && $stable(pixelData);
    endproperty
    a_stall: assert property (p_stall) else $error("Pixel word lost during stall.");
    property p_hexcl;
        !(hInterpolate && hReplicate);
    endproperty
    a_hexcl: assert property (p_hexcl) else $error("Horizontal modes both active.");
    property p_vexcl;
        !(vInterpolate && vReplicate);
    endproperty
    a_vexcl: assert property (p_vexcl) else $error("Vertical modes both active.");
    property p_key;
        !(occludeColorKey && occludeChromaKey);
    endproperty
    a_key: assert property (p_key) else $error("Both occlusion keys active.");
    property p_yuv;
        formatYuvSwap == (dataFormat == 4'h3);
    endproperty
    a_yuv: assert property (p_yuv) else $error("Byte order flag disagrees with format.");
    c_commit: cover property (lowWrite ##1 fetchHalfAlign);
    c_stall: cover property ((pixelValid && !pixelReady) [*3]);
    c_vis: cover property ($rose(windowVisible));
endmodule
bind vwfc_top vwfc_top_asserts i_chk (.*);

// ==== tb/vwfc_top_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the video window fetch control block.
module vwfc_top_tb;
    logic clk, reset_n, regWrite, regRead, vsyncPin, frameDonePin, hCoeffNonZero, vCoeffNonZero;
    logic fetchNext, pixelReady, slow, memDataValid, memDataReady, fetchHalfAlign, windowVisible;
    logic formatYuvSwap, hInterpolate, hReplicate, vInterpolate, vReplicate, occludeColorKey;
    logic occludeChromaKey, paletteVideoSelect, invertAccelClock, align16k, pixelValid;
    logic [7:0] regIndex, regWriteData, regReadData, rdv;
    logic [63:0] memData, pixelData, prev;
    logic [19:0] fetchAddress;
    logic [3:0] dataFormat;
    logic [10:0] pixelWidth;
    int mismatches = 0;
    int numChecks = 0;
    int cycles = 0;
    vwfc_top i_dut (.*);
    vwfc_mem_model i_mem (.*);
    // Free-running 25 MHz clock and a hang limit.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            endSim();
        end
    end
    task chk(input logic [63:0] g, input logic [63:0] e);
        numChecks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        #2 {regWrite, regIndex, regWriteData} = {1'b1, i, d};
        tick(1);
        regWrite = 1'b0;
    endtask
    task rd(input logic [7:0] i);
        @(posedge clk);
        #2 {regRead, regIndex} = {1'b1, i};
        tick(1);
        regRead = 1'b0;
        tick(1);
        rdv = regReadData;
    endtask
    task vsync;
        vsyncPin = 1'b1;
        tick(2);
        vsyncPin = 1'b0;
        tick(8);
    endtask
    task tResetRegs;
        logic [7:0] idx [10] = '{8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h36, 8'h42, 8'h50};
        wr(8'h50, 8'hff);
        foreach (idx[i])
        begin
            rd(idx[i]);
            chk(rdv, idx[i] == 8'h36 ? 8'h20 : 8'h00);
        end
        chk(fetchAddress, 20'h0);
    endtask
    task tStartAddr;
        wr(8'h40, 8'h01);
        wr(8'h3a, 8'hff);
        wr(8'h3e, 8'ha5);
        tick(3);
        chk(fetchAddress, 20'h0);
        wr(8'h3f, 8'h0c);
        tick(3);
        chk(fetchAddress, {7'h7f, 8'ha5, 4'hc, 1'b1});
        chk({fetchHalfAlign, invertAccelClock, align16k}, 3'b110);
        wr(8'h40, 8'h00);
        wr(8'h3a, 8'h05);
        wr(8'h3e, 8'h00);
        wr(8'h3f, 8'h00);
        tick(3);
        chk(fetchAddress, 20'h0a000);
        chk({fetchHalfAlign, invertAccelClock, align16k}, 3'b001);
    endtask
    task tPan;
        wr(8'h3b, 8'h81);
        wr(8'h36, 8'h30);
        fetchNext = 1'b1;
        tick(2);
        fetchNext = 1'b0;
        tick(1);
        chk(fetchAddress, 20'h0a000 + 20'h604);
        rd(8'h36);
        chk(rdv, 8'h30);
    endtask
    task tFormat;
        for (int c = 0; c < 6; c++)
        begin
            wr(8'h3c, {4'ha, c[3:0]});
            wr(8'h3d, 8'h3c);
            tick(3);
            chk(dataFormat, c[3:0]);
            chk(formatYuvSwap, c == 3);
            chk(pixelWidth, 11'h479);
            chk(windowVisible, 1'b0);
        end
    endtask
    task tEnable;
        vsync();
        chk(windowVisible, 1'b0);
        wr(8'h3c, 8'h11);
        tick(6);
        chk(windowVisible, 1'b0);
        vsync();
        chk(windowVisible, 1'b1);
        chk(fetchAddress, 20'h0a000);
    endtask
    task tModes;
        for (int i = 0; i < 8; i++)
        begin
            {hCoeffNonZero, vCoeffNonZero} = {2{i[2]}};
            wr(8'h42, {7'h0, i[2]});
            wr(8'h3f, {i[1], i[0], i[0], i[1], 4'h0});
            tick(3);
            chk({hInterpolate, hReplicate}, {i[1], !i[1] && i[2]});
            chk({vInterpolate, vReplicate}, {i[0], !i[0] && i[2]});
            chk({occludeColorKey, occludeChromaKey}, {i[0] && !i[2], i[0] && i[2]});
            chk(paletteVideoSelect, i[1]);
        end
    endtask
    task tPending;
        wr(8'h42, 8'h10);
        frameDonePin = 1'b1;
        tick(6);
        frameDonePin = 1'b0;
        rd(8'h42);
        chk(rdv, 8'h10);
        vsync();
        frameDonePin = 1'b1;
        tick(6);
        frameDonePin = 1'b0;
        rd(8'h42);
        chk(rdv, 8'h00);
    endtask
    task tStream;
        int n;
        n = 0;
        pixelReady = 1'b0;
        tick(30);
        chk(memDataReady, 1'b0);
        pixelReady = 1'b1;
        slow = 1'b1;
        repeat (40)
        begin
            @(negedge clk);
            if (pixelValid === 1'b1)
            begin
                if (n > 0)
                    chk(pixelData, prev + 64'h1);
                prev = pixelData;
                n++;
            end
        end
        chk(n > 12, 1'b1);
    endtask
    task endSim;
        $display("Checks %0d, mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Resets the block, then runs each scenario in turn.
    initial
    begin
        {reset_n, regWrite, regRead, vsyncPin, frameDonePin, fetchNext, slow} = 7'h0;
        {hCoeffNonZero, vCoeffNonZero, pixelReady, regIndex, regWriteData} = {3'b001, 16'h0};
        tick(6);
        reset_n = 1'b1;
        tResetRegs();
        tStartAddr();
        tPan();
        tFormat();
        tEnable();
        tModes();
        tPending();
        tStream();
        endSim();
    end
endmodule
